// ===== shared/ccl_pkg.sv
// Purpose: Constants for the per-channel local register bank of the codec.
// Assumes: Command byte bit 7 gives direction, low bits give the register index.
// Notes:   Reset values and field positions are shared by design and bench.
package ccl_pkg;

  localparam int unsigned CCL_CHANNELS   = 4;
  localparam int unsigned CCL_SLOT_W     = 7;

  // Command byte layout
  localparam int unsigned CCL_CMD_DIR_BIT = 7;
  localparam logic [6:0]  CCL_CMD_IDX_MASK = 7'h7F;

  // Register indices
  localparam logic [6:0]  CCL_IDX_PIN_MIRROR = 7'h03;
  localparam logic [6:0]  CCL_IDX_TX_SLOT    = 7'h04;
  localparam logic [6:0]  CCL_IDX_RX_SLOT    = 7'h05;
  localparam logic [6:0]  CCL_IDX_TX_LOW     = 7'h06;
  localparam logic [6:0]  CCL_IDX_TX_HIGH    = 7'h07;
  localparam logic [6:0]  CCL_IDX_PWR_GAIN   = 7'h08;
  localparam logic [6:0]  CCL_IDX_TONE       = 7'h09;

  // Pin mirror fields
  localparam int unsigned CCL_PM_SENSE_A  = 0;
  localparam int unsigned CCL_PM_SENSE_B  = 1;
  localparam int unsigned CCL_PM_BIDIR_LO = 2;
  localparam int unsigned CCL_PM_OUT_A    = 5;
  localparam int unsigned CCL_PM_OUT_B    = 6;

  // Slot registers: bit 7 is the highway select
  localparam int unsigned CCL_HWY_BIT = 7;

  // Power / gain control fields
  localparam int unsigned CCL_PG_POWERDOWN = 7;
  localparam int unsigned CCL_PG_CUTOFF    = 6;
  localparam int unsigned CCL_PG_ADC_GAIN  = 5;
  localparam int unsigned CCL_PG_DAC_GAIN  = 4;
  localparam logic [3:0]  CCL_PG_RESET     = 4'h8;

  // Tone control fields
  localparam int unsigned CCL_TN_COEF1 = 3;
  localparam int unsigned CCL_TN_COEF0 = 2;
  localparam int unsigned CCL_TN_ON1   = 1;
  localparam int unsigned CCL_TN_ON0   = 0;
  localparam logic [3:0]  CCL_TN_RESET = 4'h0;

  localparam logic [1:0]  CCL_OUT_RESET  = 2'h0;
  localparam logic        CCL_HWY_RESET  = 1'b0;
  localparam logic [7:0]  CCL_READ_ZERO  = 8'h00;

endpackage : ccl_pkg

// ===== hdl/ccl_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin levels.
// Assumes: Each bit is an independent slow level; no bus coherency needed.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module ccl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,    // System clock
  input  wire logic             sys_rst, // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : ccl_sync

// ===== hdl/ccl_regs.sv
// Purpose: Local control registers of a four-channel voice codec, one copy each channel.
// Assumes: Serial framing is decoded upstream into one command byte plus one data byte.
// Notes:   Reads answer from the lowest selected channel; writes reach every selected one.
//
// Functional notes
// RL1: Command bit 7 selects write, low bits index
// RL2: Pin mirror shows seven signalling pin levels
// RL3: Output-configured bidir pins ignore mirror writes
// RL4: Transmit slot field; channel N+1 resets N
// RL5: Transmit slot bit 7 picks transmit highway
// RL6: Receive slot field; channel N+1 resets N
// RL7: Receive slot bit 7 picks receive highway
// RL8: Low monitor byte, read-only, command 06H
// RL9: High monitor byte; zero in companded coding
// RL10: Monitor reads leave transmit sample untouched
// RL11: Control bit 7 powers channel down, reset set
// RL12: Control bit 6 cuts receive PCM path
// RL13: Control bit 5 adds 6 dB ADC gain
// RL14: Control bit 4 drops DAC by 6 dB
// RL15: Host writes zeros in control low nibble
// RL16: Tone bits 3,2 pick RAM coefficients
// RL17: Tone bits 1,0 enable generators, reset off
// RL18: Access hits only selected channels, independent copies
`timescale 1ns/1ps
module ccl_regs
  import ccl_pkg::*;
#(
  parameter int unsigned CH = ccl_pkg::CCL_CHANNELS
) (
  input  wire logic                  mclk,             // 250 MHz system clock
  input  wire logic                  sys_rst,          // Synchronous reset, active high
  // Decoded host serial port
  input  wire logic                  cmd_valid,        // One-cycle pulse: command plus data
  input  wire logic [7:0]            cmd_byte,         // Direction and register index
  input  wire logic [7:0]            cmd_wdata,        // Data byte of a write
  input  wire logic [CH-1:0]         chan_select,      // Channels addressed by this access
  output logic                       rd_valid,         // One-cycle pulse: read answer ready
  output logic                       rd_hit,           // Read addressed a register here
  output logic      [7:0]            rd_data,          // Read answer byte
  // Signalling pins
  input  wire logic [CH-1:0]         sense_in_a,       // First sense input pin
  input  wire logic [CH-1:0]         sense_in_b,       // Second sense input pin
  input  wire logic [CH-1:0][2:0]    bidir_sig_in,     // Bidir pins a,b,c levels
  input  wire logic [CH-1:0][2:0]    bidir_dir_out,    // Bidir configured as output
  input  wire logic [CH-1:0][2:0]    global_out_val,   // Global output registers a,b,c
  output logic      [CH-1:0][2:0]    bidir_sig_out,    // Bidir drive value
  output logic      [CH-1:0][2:0]    bidir_sig_oe_n,   // Bidir enable, low drives
  output logic      [CH-1:0]         sig_out_a,        // First signalling output
  output logic      [CH-1:0]         sig_out_b,        // Second signalling output
  // Transmit sample path
  input  wire logic                  linear_mode,      // 1 linear 16-bit, 0 companded
  input  wire logic [CH-1:0][15:0]   tx_sample,        // Current transmit sample
  input  wire logic [CH-1:0]         tx_sample_valid,  // Sample strobe
  output logic      [CH-1:0][15:0]   tx_sample_out,    // Sample to the highway
  output logic      [CH-1:0]         tx_sample_out_vld, // Strobe to the highway
  // Channel configuration
  output logic      [CH-1:0][6:0]    tx_slot_sel,      // Transmit slot or slot group
  output logic      [CH-1:0]         tx_highway_sel,   // 0 first line, 1 second line
  output logic      [CH-1:0][6:0]    rx_slot_sel,      // Receive slot or slot group
  output logic      [CH-1:0]         rx_highway_sel,   // 0 first line, 1 second line
  output logic      [CH-1:0]         chan_powerdown,   // Channel powered down
  output logic      [CH-1:0]         rx_path_cutoff,   // Receive PCM path cut off
  output logic      [CH-1:0]         adc_gain_step,    // +6 dB A/D step
  output logic      [CH-1:0]         dac_gain_step,    // -6 dB D/A step
  output logic      [CH-1:0]         tone1_coef_src,   // Tone 1 coefficients from RAM
  output logic      [CH-1:0]         tone0_coef_src,   // Tone 0 coefficients from RAM
  output logic      [CH-1:0]         tone1_on,         // Tone generator 1 enabled
  output logic      [CH-1:0]         tone0_on          // Tone generator 0 enabled
);

  import ccl_pkg::*;

  // Slot reset value is the channel number counted from zero
  function automatic logic [6:0] slot_reset(input int unsigned ch);
    slot_reset = 7'(ch);
  endfunction : slot_reset

  function automatic logic is_index(input logic [7:0] cmd, input logic [6:0] idx);
    is_index = ((cmd[6:0] & CCL_CMD_IDX_MASK) == idx);
  endfunction : is_index

  logic                  cmd_write;
  logic                  cmd_read;
  logic [CH-1:0]         sense_a_s;
  logic [CH-1:0]         sense_b_s;
  logic [CH-1:0][2:0]    bidir_s;

  logic [CH-1:0][1:0]    out_pins_reg;
  logic [CH-1:0][2:0]    bidir_wr_reg;
  logic [CH-1:0][7:0]    tx_slot_reg;
  logic [CH-1:0][7:0]    rx_slot_reg;
  logic [CH-1:0][3:0]    pwr_gain_reg;
  logic [CH-1:0][3:0]    tone_reg;

  logic [7:0]            rd_next;
  logic                  hit_next;

  assign cmd_write = cmd_valid && cmd_byte[CCL_CMD_DIR_BIT];  // RL1
  assign cmd_read  = cmd_valid && !cmd_byte[CCL_CMD_DIR_BIT]; // RL1

  // Pin levels come from outside the clock domain
  ccl_sync #(
    .WIDTH (5*CH)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({sense_in_a, sense_in_b, bidir_sig_in}),
    .sync_out ({sense_a_s, sense_b_s, bidir_s})
  );

  // Signalling outputs and mirror-held bidir values
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_pins_reg <= '0;
      bidir_wr_reg <= '0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (cmd_write && chan_select[c] && is_index(cmd_byte, CCL_IDX_PIN_MIRROR)) begin // RL18
          out_pins_reg[c] <= {cmd_wdata[CCL_PM_OUT_B], cmd_wdata[CCL_PM_OUT_A]}; // RL2
          for (int k = 0; k < 3; k++) begin
            // A pin owned by its global register keeps its stored value
            if (!bidir_dir_out[c][k]) begin // RL3
              bidir_wr_reg[c][k] <= cmd_wdata[CCL_PM_BIDIR_LO+k];
            end
          end
        end
      end
    end
  end

  // Output-configured bidir pins follow the global register only
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      sig_out_a[c] = out_pins_reg[c][0];
      sig_out_b[c] = out_pins_reg[c][1];
      for (int k = 0; k < 3; k++) begin
        // An input-configured pin only latches the mirror write; its enable stays off
        bidir_sig_out[c][k]  = bidir_dir_out[c][k] ? global_out_val[c][k] // RL3
                                                   : bidir_wr_reg[c][k];
        bidir_sig_oe_n[c][k] = !bidir_dir_out[c][k];
      end
    end
  end

  // Slot and highway registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int c = 0; c < CH; c++) begin
        tx_slot_reg[c] <= {CCL_HWY_RESET, slot_reset(c)}; // RL4 RL5
        rx_slot_reg[c] <= {CCL_HWY_RESET, slot_reset(c)}; // RL6 RL7
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (cmd_write && chan_select[c]) begin // RL18
          if (is_index(cmd_byte, CCL_IDX_TX_SLOT)) begin
            tx_slot_reg[c] <= cmd_wdata; // RL4 RL5
          end
          if (is_index(cmd_byte, CCL_IDX_RX_SLOT)) begin
            rx_slot_reg[c] <= cmd_wdata; // RL6 RL7
          end
        end
      end
    end
  end

  // Power, gain and tone controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int c = 0; c < CH; c++) begin
        pwr_gain_reg[c] <= CCL_PG_RESET; // RL11
        tone_reg[c]     <= CCL_TN_RESET; // RL17
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (cmd_write && chan_select[c]) begin // RL18
          // Low nibble is expected zero from the host and is not stored
          if (is_index(cmd_byte, CCL_IDX_PWR_GAIN)) begin
            pwr_gain_reg[c] <= cmd_wdata[7:4]; // RL15
          end
          if (is_index(cmd_byte, CCL_IDX_TONE)) begin
            tone_reg[c] <= cmd_wdata[3:0]; // RL16 RL17
          end
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CH; c++) begin
      tx_slot_sel[c]    = tx_slot_reg[c][6:0];            // RL4
      tx_highway_sel[c] = tx_slot_reg[c][CCL_HWY_BIT];    // RL5
      rx_slot_sel[c]    = rx_slot_reg[c][6:0];            // RL6
      rx_highway_sel[c] = rx_slot_reg[c][CCL_HWY_BIT];    // RL7
      chan_powerdown[c] = pwr_gain_reg[c][CCL_PG_POWERDOWN-4]; // RL11
      rx_path_cutoff[c] = pwr_gain_reg[c][CCL_PG_CUTOFF-4];    // RL12
      adc_gain_step[c]  = pwr_gain_reg[c][CCL_PG_ADC_GAIN-4];  // RL13
      dac_gain_step[c]  = pwr_gain_reg[c][CCL_PG_DAC_GAIN-4];  // RL14
      tone1_coef_src[c] = tone_reg[c][CCL_TN_COEF1];      // RL16
      tone0_coef_src[c] = tone_reg[c][CCL_TN_COEF0];      // RL16
      tone1_on[c]       = tone_reg[c][CCL_TN_ON1];        // RL17
      tone0_on[c]       = tone_reg[c][CCL_TN_ON0];        // RL17
    end
  end

  // The highway copy never looks at the host port, so a read cannot stall it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_sample_out     <= '0;
      tx_sample_out_vld <= '0;
    end else begin
      tx_sample_out_vld <= tx_sample_valid; // RL10
      for (int c = 0; c < CH; c++) begin
        if (tx_sample_valid[c]) begin
          tx_sample_out[c] <= tx_sample[c]; // RL10
        end
      end
    end
  end

  // Read answer from the lowest selected channel
  always_comb begin
    int unsigned sel;
    logic        any;
    sel      = 0;
    any      = 1'b0;
    rd_next  = CCL_READ_ZERO;
    hit_next = 1'b0;
    for (int c = CH-1; c >= 0; c--) begin
      if (chan_select[c]) begin
        sel = c;
        any = 1'b1;
      end
    end
    if (any) begin
      hit_next = 1'b1;
      unique case (cmd_byte[6:0])
        CCL_IDX_PIN_MIRROR: begin
          rd_next = {1'b0, out_pins_reg[sel], bidir_s[sel],
                     sense_b_s[sel], sense_a_s[sel]}; // RL2
        end
        CCL_IDX_TX_SLOT:  rd_next = tx_slot_reg[sel];
        CCL_IDX_RX_SLOT:  rd_next = rx_slot_reg[sel];
        CCL_IDX_TX_LOW:   rd_next = tx_sample_out[sel][7:0]; // RL8 RL10
        CCL_IDX_TX_HIGH: begin
          rd_next = linear_mode ? tx_sample_out[sel][15:8] : CCL_READ_ZERO; // RL9
        end
        CCL_IDX_PWR_GAIN: rd_next = {pwr_gain_reg[sel], 4'h0};
        CCL_IDX_TONE:     rd_next = {4'h0, tone_reg[sel]};
        default: begin
          rd_next  = CCL_READ_ZERO;
          hit_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
      rd_data  <= CCL_READ_ZERO;
    end else begin
      rd_valid <= cmd_read; // RL1
      if (cmd_read) begin
        rd_hit  <= hit_next;
        rd_data <= rd_next;
      end
    end
  end

endmodule : ccl_regs

// ===== sim/ccl_regs_props.sv
// Purpose: Concurrent checks on the ports of the local register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Channels 0 and 1 stand in for all; writes reach the selected ones only.
`timescale 1ns/1ps
module ccl_regs_props #(
  parameter int unsigned CH = 4
) (
  input wire logic                mclk,              // Clock
  input wire logic                sys_rst,           // Reset
  input wire logic                cmd_valid,         // Access strobe
  input wire logic [7:0]          cmd_byte,          // Command
  input wire logic [7:0]          cmd_wdata,         // Write data
  input wire logic [CH-1:0]       chan_select,       // Channel mask
  input wire logic                rd_valid,          // Read pulse
  input wire logic [7:0]          rd_data,           // Read byte
  input wire logic [CH-1:0][2:0]  bidir_dir_out,     // Bidir is output
  input wire logic [CH-1:0][2:0]  global_out_val,    // Global drive values
  input wire logic [CH-1:0][2:0]  bidir_sig_out,     // Bidir drive
  input wire logic [CH-1:0][2:0]  bidir_sig_oe_n,    // Bidir enable
  input wire logic                linear_mode,       // Coding
  input wire logic [CH-1:0][15:0] tx_sample,         // Sample in
  input wire logic [CH-1:0]       tx_sample_valid,   // Sample strobe
  input wire logic [CH-1:0][15:0] tx_sample_out,     // Sample out
  input wire logic [CH-1:0]       tx_sample_out_vld, // Out strobe
  input wire logic [CH-1:0][6:0]  tx_slot_sel,       // Tx slot
  input wire logic [CH-1:0]       tx_highway_sel,    // Tx highway
  input wire logic [CH-1:0]       chan_powerdown,    // Power down
  input wire logic [CH-1:0]       rx_path_cutoff     // Rx cutoff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic rd_cmd;
  assign rd_cmd = cmd_valid && !cmd_byte[7];
  property p_rd_pulse; rd_cmd |=> rd_valid; endproperty
  a_rd_pulse : assert property (p_rd_pulse) else $error("read gave no answer");
  property p_rd_only; !rd_cmd |=> !rd_valid; endproperty
  a_rd_only : assert property (p_rd_only) else $error("answer without read");
  property p_tx_slot;
    cmd_valid && cmd_byte == 8'h84 && chan_select[1]
      |=> {tx_highway_sel[1], tx_slot_sel[1]} == $past(cmd_wdata);
  endproperty
  a_tx_slot : assert property (p_tx_slot) else $error("tx slot not written");
  property p_pwr;
    cmd_valid && cmd_byte == 8'h88 && chan_select[0]
      |=> {chan_powerdown[0], rx_path_cutoff[0]} == $past(cmd_wdata[7:6]);
  endproperty
  a_pwr : assert property (p_pwr) else $error("power bits not written");
  // Mirror writes must never reach a pin driven from the global registers
  property p_bidir;
    bidir_sig_oe_n == ~bidir_dir_out
      && (bidir_sig_out & bidir_dir_out) == (global_out_val & bidir_dir_out);
  endproperty
  a_bidir : assert property (p_bidir) else $error("bidir drive wrong");
  property p_sample;
    tx_sample_valid[0] |=> tx_sample_out_vld[0] && tx_sample_out[0] == $past(tx_sample[0]);
  endproperty
  a_sample : assert property (p_sample) else $error("sample altered");
  property p_mon_lo;
    rd_cmd && cmd_byte[6:0] == 7'h06 && chan_select[0]
      |=> rd_data == $past(tx_sample_out[0][7:0]);
  endproperty
  a_mon_lo : assert property (p_mon_lo) else $error("low monitor wrong");
  property p_mon_hi;
    rd_cmd && cmd_byte[6:0] == 7'h07 && !linear_mode && |chan_select |=> rd_data == 8'h00;
  endproperty
  a_mon_hi : assert property (p_mon_hi) else $error("high monitor not zero");
  property p_sel_only; cmd_valid && !chan_select[1] |=> $stable(tx_slot_sel[1]); endproperty
  a_sel_only : assert property (p_sel_only) else $error("unselected changed");
  c_tx_wr : cover property (cmd_valid && cmd_byte == 8'h84);
  c_hi_rd : cover property (rd_cmd && cmd_byte == 8'h07 && linear_mode);
  c_smp : cover property (tx_sample_valid[0]);
endmodule : ccl_regs_props

bind ccl_regs ccl_regs_props #(.CH(CH)) u_props (
  .mclk, .sys_rst, .cmd_valid, .cmd_byte, .cmd_wdata, .chan_select, .rd_valid, .rd_data,
  .bidir_dir_out, .global_out_val, .bidir_sig_out, .bidir_sig_oe_n, .linear_mode,
  .tx_sample, .tx_sample_valid, .tx_sample_out, .tx_sample_out_vld, .tx_slot_sel,
  .tx_highway_sel, .chan_powerdown, .rx_path_cutoff
);

// ===== sim/ccl_host_model.sv
// Purpose: Host microcontroller side of the decoded serial port.
// Assumes: The bench raises req for one cycle per access.
// Notes:   Idle lines carry a changing pattern so a stale value never looks valid.
`timescale 1ns/1ps
module ccl_host_model (
  input  wire logic       mclk,       // Clock
  input  wire logic       req,        // Bench asks for one access
  input  wire logic [7:0] req_cmd,    // Command byte
  input  wire logic [7:0] req_data,   // Write data
  input  wire logic [3:0] req_sel,    // Channel mask
  output logic            cmd_valid,  // Strobe to the bank
  output logic      [7:0] cmd_byte,   // Command to the bank
  output logic      [7:0] cmd_wdata,  // Data to the bank
  output logic      [3:0] chan_select // Mask to the bank
);
  logic [7:0] idle_pat = 8'hA5;
  always @(posedge mclk) begin
    idle_pat <= idle_pat + 8'h5B;
  end
  assign cmd_valid   = req;
  assign cmd_byte    = req ? req_cmd : idle_pat;
  // Control writes go out with a clear low nibble, as a real host must
  assign cmd_wdata   = !req ? ~idle_pat
                     : (req_cmd == 8'h88) ? {req_data[7:4], 4'h0} : req_data;
  assign chan_select = req ? req_sel : idle_pat[3:0];
endmodule : ccl_host_model

// ===== sim/ccl_regs_tb_top.sv
// Purpose: Self-checking bench for the local register bank.
// Assumes: Inputs change at falling edges; one access per two cycles.
// Notes:   Expected values come from the register layout, never from the design.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ccl_regs_tb_top;
  import ccl_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, req = 1'b0, linear_mode = 1'b0;
  logic [7:0] req_cmd = 8'h00, req_data = 8'h00;
  logic [3:0] req_sel = 4'h0, sense_in_a = '0, sense_in_b = '0, tx_sample_valid = '0;
  logic [3:0][2:0] bidir_sig_in = '0, bidir_dir_out = '0, global_out_val = '0;
  logic [3:0][15:0] tx_sample = '0;
  logic [7:0] cmd_byte, cmd_wdata, rd_data;
  logic [3:0] chan_select, tx_sample_out_vld, sig_out_a, sig_out_b, tx_highway_sel;
  logic [3:0] rx_highway_sel, chan_powerdown, rx_path_cutoff, adc_gain_step, dac_gain_step;
  logic [3:0] tone1_coef_src, tone0_coef_src, tone1_on, tone0_on;
  logic cmd_valid, rd_valid, rd_hit;
  logic [3:0][2:0] bidir_sig_out, bidir_sig_oe_n;
  logic [3:0][15:0] tx_sample_out;
  logic [3:0][6:0] tx_slot_sel, rx_slot_sel;
  int errors = 0, n_compared = 0, cyc = 0;
  ccl_host_model host (.mclk, .req, .req_cmd, .req_data, .req_sel, .cmd_valid, .cmd_byte,
    .cmd_wdata, .chan_select);
  ccl_regs #(.CH(4)) uut (.mclk, .sys_rst, .cmd_valid, .cmd_byte, .cmd_wdata, .chan_select,
    .rd_valid, .rd_hit, .rd_data, .sense_in_a, .sense_in_b, .bidir_sig_in, .bidir_dir_out,
    .global_out_val, .bidir_sig_out, .bidir_sig_oe_n, .sig_out_a, .sig_out_b, .linear_mode,
    .tx_sample, .tx_sample_valid, .tx_sample_out, .tx_sample_out_vld, .tx_slot_sel,
    .tx_highway_sel, .rx_slot_sel, .rx_highway_sel, .chan_powerdown, .rx_path_cutoff,
    .adc_gain_step, .dac_gain_step, .tone1_coef_src, .tone0_coef_src, .tone1_on, .tone0_on);
  always #2 mclk = ~mclk;
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // The strobe drops a full cycle before the next access, so req never toggles twice at once
  task automatic access(input logic [7:0] cmd, input logic [7:0] data, input logic [3:0] sel);
    @(negedge mclk);
    req_cmd = cmd;
    req_data = data;
    req_sel = sel;
    req = 1'b1;
    @(negedge mclk);
    req = 1'b0;
  endtask : access
  task automatic rd(input logic [7:0] idx, input logic [3:0] sel, input logic [7:0] exp);
    access(idx, 8'h00, sel);
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, exp)
  endtask : rd
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    for (int c = 0; c < 4; c++) begin
      rd(8'h04, 4'(1 << c), {1'b0, 7'(c)});
      rd(8'h05, 4'(1 << c), {1'b0, 7'(c)});
      rd(8'h08, 4'(1 << c), 8'h80);
      rd(8'h09, 4'(1 << c), 8'h00);
    end
    access(8'h84, 8'hFF, 4'h2);
    access(8'h85, 8'h80, 4'hF);
    rd(8'h04, 4'h2, 8'hFF);
    rd(8'h04, 4'h1, 8'h00);
    `CHK({tx_highway_sel, rx_highway_sel}, 8'h2F)
    `CHK(rx_slot_sel, 28'h0)
    `CHK(tx_slot_sel, {7'h03, 7'h02, 7'h7F, 7'h00})
    for (int k = 4; k < 8; k++) begin
      access(8'h88, 8'h0F | (8'h01 << k), 4'h1);
      rd(8'h08, 4'h1, 8'h01 << k);
      `CHK({chan_powerdown[0], rx_path_cutoff[0], adc_gain_step[0], dac_gain_step[0]},
        4'(1 << (k - 4)))
    end
    for (int k = 0; k < 4; k++) begin
      access(8'h89, 8'hF0 | (8'h01 << k), 4'h1);
      rd(8'h09, 4'h1, 8'h01 << k);
      `CHK({tone1_coef_src[0], tone0_coef_src[0], tone1_on[0], tone0_on[0]}, 4'(1 << k))
    end
    sense_in_a[0] = 1'b1;
    bidir_sig_in[0] = 3'b101;
    bidir_dir_out[0] = 3'b111;
    global_out_val[0] = 3'b010;
    access(8'h83, 8'h7C, 4'h1);
    rd(8'h03, 4'h1, 8'h75);
    `CHK({sig_out_b[0], sig_out_a[0], bidir_sig_out[0], bidir_sig_oe_n[0]}, 8'hD0)
    linear_mode = 1'b1;
    tx_sample[0] = 16'hA5C3;
    tx_sample_valid[0] = 1'b1;
    @(negedge mclk);
    tx_sample_valid[0] = 1'b0;
    rd(8'h06, 4'h1, 8'hC3);
    access(8'h86, 8'h00, 4'h1);
    rd(8'h06, 4'h1, 8'hC3);
    rd(8'h07, 4'h1, 8'hA5);
    `CHK(tx_sample_out[0], 16'hA5C3)
    linear_mode = 1'b0;
    rd(8'h07, 4'h1, 8'h00);
    `CHK(rd_hit, 1'b1)
    rd(8'h0A, 4'h1, 8'h00);
    `CHK(rd_hit, 1'b0)
    final_report();
  end
endmodule : ccl_regs_tb_top
